//--- pkg/cfg_startup_params.svh
// constants for the configuration check and startup sequencer
// assumes inclusion by bare name from the package and design files
`ifndef CFG_STARTUP_PARAMS_SVH
`define CFG_STARTUP_PARAMS_SVH

// startup machine geometry
`define CFG_PHASE_W        3
`define CFG_LAST_PHASE     3'h7
`define CFG_FIRST_PHASE    3'h0

// default phase assignment of the startup events
`define CFG_DEF_GTS_PHASE  3'h5
`define CFG_DEF_GWE_PHASE  3'h6
`define CFG_DEF_DONE_PHASE 3'h4

// memory clearing length in config clock cycles
`define CFG_CLEAR_CYCLES   16

// data path and check sum
`define CFG_WORD_W         32
`define CFG_CRC_POLY       32'h04c1_1db7
`define CFG_CRC_INIT       32'hffff_ffff
`define CFG_SYNC_WORD      32'h5a3c_c3a5

// reset values of pin and global outputs
`define CFG_MODE_RST       3'h0
`define CFG_GTS_RST        1'b1
`define CFG_GWE_RST        1'b0

`endif

//--- pkg/cfg_startup_pkg.sv
// types shared by the configuration check and startup sequencer
// assumes the params header is on the include path
`default_nettype none
`include "cfg_startup_params.svh"

package cfg_startup_pkg;

  typedef logic [`CFG_PHASE_W-1:0] phase_t;
  typedef logic [`CFG_WORD_W-1:0]  word_t;

  // top-level sequence of the configuration logic
  typedef enum logic [3:0] {
    st_clear,
    st_wait_init,
    st_wait_sync,
    st_load,
    st_gsr,
    st_precheck,
    st_startup,
    st_running,
    st_failed
  } cfg_state_t;

endpackage

`default_nettype wire

//--- core/crc_accum.sv
// running check sum over configuration words, one word per clock
// assumes the caller clears it before a new bitstream
`default_nettype none
`include "cfg_startup_params.svh"

module crc_accum #(
  parameter int W = `CFG_WORD_W
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_clear,
  input  wire logic         i_en,
  input  wire logic [W-1:0] i_word,
  output logic      [W-1:0] o_crc
);

  logic [31:0] crc_r;
  logic [31:0] crc_nxt;

  ////////////////////////////////////////////////////////////////////////
  // one lfsr step per data bit, msb first; unrolled by the loop
  always_comb begin
    crc_nxt = crc_r;
    for (int b = W - 1; b >= 0; b--) begin
      if (crc_nxt[31] ^ i_word[b]) begin
        crc_nxt = {crc_nxt[30:0], 1'b0} ^ `CFG_CRC_POLY;
      end else begin
        crc_nxt = {crc_nxt[30:0], 1'b0};
      end
    end
  end

  // clear wins over accumulate so a retry starts clean
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      crc_r <= `CFG_CRC_INIT;
    end else if (i_clear) begin
      crc_r <= `CFG_CRC_INIT;
    end else if (i_en) begin
      crc_r <= crc_nxt;
    end
  end

  assign o_crc = crc_r[W-1:0];

endmodule

`default_nettype wire

//--- core/cfg_startup_seq.sv
// configuration check sum and startup sequencer, runs on config_clock
// assumes pins arrive unsynchronised; word strobes come from same clock
//
// Summary of operation
// - check sum is compared after each frame write and before startup
// - a failed check pulls the init/error pin low
// - a failed check aborts startup, done and init both stay low
// - program pin low fully resets the configuration logic for a retry
// - after the last frame a one cycle global set/reset pulse is given
// - startup is an eight phase machine into normal operation
// - in its phase the global output tristate is deasserted
// - in its phase the global write enable is asserted
// - end of startup flag rises in the last phase and is readable
// - event phases are programmable, optional lock and match waits
// - done phase holds until the done pin is seen high
// - done release is open drain or actively driven high by option
// - done pipe option adds one register stage to the done sample
// - startup finishes four to ten cycles after done release
// - init stays low until memory clearing ends after program release
// - init may be held low outside; mode pins sampled at its rise
// - words are ignored until the synchronisation word is received
`default_nettype none
`include "cfg_startup_params.svh"

module cfg_startup_seq
  import cfg_startup_pkg::*;
#(
  parameter int CLEAR_CYCLES = `CFG_CLEAR_CYCLES
) (
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  input  wire logic                   i_program_reset_n,
  input  wire logic                   i_init_in,
  input  wire logic                   i_done_in,
  input  wire logic [2:0]             i_mode_pins,
  input  wire logic                   i_word_valid,
  input  wire cfg_startup_pkg::word_t i_word,
  input  wire logic                   i_write_end,
  input  wire logic                   i_last_frame,
  input  wire cfg_startup_pkg::word_t i_expected_crc,
  input  wire cfg_startup_pkg::phase_t i_gts_phase,
  input  wire cfg_startup_pkg::phase_t i_gwe_phase,
  input  wire cfg_startup_pkg::phase_t i_done_phase,
  input  wire logic                   i_lock_wait_en,
  input  wire cfg_startup_pkg::phase_t i_lock_phase,
  input  wire logic                   i_clocks_locked,
  input  wire logic                   i_match_wait_en,
  input  wire cfg_startup_pkg::phase_t i_match_phase,
  input  wire logic                   i_impedance_matched,
  input  wire logic                   i_drive_done,
  input  wire logic                   i_done_pipe,
  output logic                        o_init_out,
  output logic                        o_init_oe,
  output logic                        o_done_out,
  output logic                        o_done_oe,
  output logic [2:0]                  o_mode,
  output logic                        o_sync_seen,
  output logic                        o_crc_error,
  output logic                        o_global_set_reset,
  output logic                        o_global_output_tristate,
  output logic                        o_global_write_enable,
  output logic                        o_end_of_startup_flag,
  output cfg_startup_pkg::phase_t     o_phase
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: first stage feeds only the second
  logic [1:0] prog_sync_r;
  logic [1:0] init_sync_r;
  logic [1:0] done_sync_r;
  logic [2:0] mode_s1_r;
  logic [2:0] mode_s2_r;
  logic       init_prev_r;
  logic       done_pipe_r;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      prog_sync_r <= 2'h0;
      init_sync_r <= 2'h0;
      done_sync_r <= 2'h0;
      mode_s1_r   <= `CFG_MODE_RST;
      mode_s2_r   <= `CFG_MODE_RST;
      init_prev_r <= 1'b0;
      done_pipe_r <= 1'b0;
    end else begin
      prog_sync_r <= {prog_sync_r[0], i_program_reset_n};
      init_sync_r <= {init_sync_r[0], i_init_in};
      done_sync_r <= {done_sync_r[0], i_done_in};
      mode_s1_r   <= i_mode_pins;
      mode_s2_r   <= mode_s1_r;
      init_prev_r <= init_sync_r[1];
      done_pipe_r <= done_sync_r[1];
    end
  end

  wire prog_low  = ~prog_sync_r[1];
  wire init_rise = init_sync_r[1] & ~init_prev_r;
  wire done_high = i_done_pipe ? done_pipe_r : done_sync_r[1];

  ////////////////////////////////////////////////////////////////////////
  // check sum engine, cleared while the program pin is low
  word_t crc_val;
  cfg_state_t state_r;
  cfg_state_t state_nxt;

  wire crc_clear = prog_low | (state_r == st_clear);
  wire crc_en    = i_word_valid & (state_r == st_load);
  wire crc_bad   = (crc_val != i_expected_crc);

  crc_accum #(
    .W (`CFG_WORD_W)
  ) u_crc (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_clear (crc_clear),
    .i_en    (crc_en),
    .i_word  (i_word),
    .o_crc   (crc_val)
  );

  ////////////////////////////////////////////////////////////////////////
  // startup phase stepping
  phase_t phase_r;
  logic [15:0] clear_cnt_r;

  wire hold_done  = (phase_r == i_done_phase) & ~done_high;
  wire hold_lock  = i_lock_wait_en & (phase_r == i_lock_phase)
                    & ~i_clocks_locked;
  wire hold_match = i_match_wait_en & (phase_r == i_match_phase)
                    & ~i_impedance_matched;
  wire phase_step = (state_r == st_startup) & ~hold_done & ~hold_lock
                    & ~hold_match;
  wire clear_done = (clear_cnt_r == 16'(CLEAR_CYCLES - 1));

  wire [`CFG_PHASE_W-1:0] phase_nxt = phase_step ? phase_r + 3'h1
                                                 : phase_r;

  ////////////////////////////////////////////////////////////////////////
  // sequence of the configuration logic
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      st_clear: begin
        if (clear_done) begin
          state_nxt = st_wait_init;
        end
      end
      st_wait_init: begin
        if (init_rise) begin
          state_nxt = st_wait_sync;
        end
      end
      st_wait_sync: begin
        if (i_word_valid && i_word == `CFG_SYNC_WORD) begin
          state_nxt = st_load;
        end
      end
      st_load: begin
        if (i_write_end && crc_bad) begin
          state_nxt = st_failed;
        end else if (i_last_frame) begin
          state_nxt = st_gsr;
        end
      end
      st_gsr: begin
        state_nxt = st_precheck;
      end
      st_precheck: begin
        state_nxt = crc_bad ? st_failed : st_startup;
      end
      st_startup: begin
        if (phase_step && phase_r == `CFG_LAST_PHASE) begin
          state_nxt = st_running;
        end
      end
      st_running: begin
        state_nxt = st_running;
      end
      st_failed: begin
        state_nxt = st_failed;
      end
      default: begin
        state_nxt = st_clear;
      end
    endcase
    if (prog_low) begin
      state_nxt = st_clear;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state, phase and clearing counter
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r     <= st_clear;
      phase_r     <= `CFG_FIRST_PHASE;
      clear_cnt_r <= 16'h0000;
    end else begin
      state_r     <= state_nxt;
      phase_r     <= (state_r == st_startup) ? phase_nxt
                                             : `CFG_FIRST_PHASE;
      clear_cnt_r <= (state_r == st_clear && !prog_low && !clear_done)
                     ? clear_cnt_r + 16'h0001 : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // decoded levels for the registered outputs
  wire starting   = (state_nxt == st_startup) | (state_nxt == st_running);
  // next state, so events set to phase 0 take effect in phase 0
  wire in_start   = (state_nxt == st_startup);
  wire in_run     = (state_nxt == st_running);
  wire gts_nxt    = ~(in_run | (in_start & phase_nxt >= i_gts_phase));
  wire gwe_nxt    = in_run | (in_start & phase_nxt >= i_gwe_phase);
  wire done_rel   = in_run | (in_start & phase_nxt >= i_done_phase);
  wire eos_nxt    = in_run | (in_start & phase_nxt == `CFG_LAST_PHASE);
  wire init_low   = (state_nxt == st_clear) | (state_nxt == st_failed);

  // mode pins are caught once, at the init rise
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_mode <= `CFG_MODE_RST;
    end else if (state_r == st_wait_init && init_rise) begin
      o_mode <= mode_s2_r;
    end
  end

  // pins: init is open drain, done depends on the drive option
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_init_out <= 1'b0;
      o_init_oe  <= 1'b1;
      o_done_out <= 1'b0;
      o_done_oe  <= 1'b1;
    end else begin
      o_init_out <= 1'b0;
      o_init_oe  <= init_low;
      o_done_out <= done_rel & starting & i_drive_done;
      o_done_oe  <= ~(done_rel & starting) | i_drive_done;
    end
  end

  // globals and status; the set/reset pulse lasts exactly one cycle
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_global_set_reset       <= 1'b0;
      o_global_output_tristate <= `CFG_GTS_RST;
      o_global_write_enable    <= `CFG_GWE_RST;
      o_end_of_startup_flag    <= 1'b0;
      o_crc_error              <= 1'b0;
      o_sync_seen              <= 1'b0;
      o_phase                  <= `CFG_FIRST_PHASE;
    end else begin
      o_global_set_reset       <= (state_nxt == st_gsr);
      o_global_output_tristate <= gts_nxt;
      o_global_write_enable    <= gwe_nxt;
      o_end_of_startup_flag    <= eos_nxt;
      o_crc_error              <= (state_nxt == st_failed);
      o_sync_seen              <= (state_nxt != st_clear)
                                  & (state_nxt != st_wait_init)
                                  & (state_nxt != st_wait_sync);
      o_phase                  <= phase_nxt;
    end
  end

endmodule

`default_nettype wire

//--- tb/cfg_peer_model.sv
// peer devices and pull-ups on the shared done and init wires
// assumes the bench changes the hold requests off the clock edge
`default_nettype none
module cfg_peer_model (
  input  wire logic i_done_out,
  input  wire logic i_done_oe,
  input  wire logic i_init_out,
  input  wire logic i_init_oe,
  input  wire logic i_hold_done,
  input  wire logic i_hold_init,
  output logic      o_done_wire,
  output logic      o_init_wire
);
  timeunit 1ns;
  timeprecision 1ns;
  // peers hold done
  // a peer pulling low wins over the pull-up; the rise is immediate
  assign o_done_wire = !(i_hold_done || (i_done_oe && !i_done_out));
  assign o_init_wire = !(i_hold_init || (i_init_oe && !i_init_out));
endmodule
`default_nettype wire

//--- tb/cfg_startup_seq_asserts.sv
// concurrent checks on the sequencer ports
// assumes a bind onto cfg_startup_seq, one clock domain
`default_nettype none
module cfg_startup_seq_asserts (
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic       i_done_in,
  input wire logic       i_write_end,
  input wire logic       i_last_frame,
  input wire logic [2:0] i_gts_phase,
  input wire logic [2:0] i_gwe_phase,
  input wire logic [2:0] i_done_phase,
  input wire logic       i_lock_wait_en,
  input wire logic       i_match_wait_en,
  input wire logic       i_done_pipe,
  input wire logic       o_init_out,
  input wire logic       o_init_oe,
  input wire logic       o_done_out,
  input wire logic       o_done_oe,
  input wire logic       o_sync_seen,
  input wire logic       o_crc_error,
  input wire logic       o_global_set_reset,
  input wire logic       o_global_output_tristate,
  input wire logic       o_global_write_enable,
  input wire logic       o_end_of_startup_flag,
  input wire logic [2:0] o_phase
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic rel;
  // done counts as released when floating or driven high
  assign rel = !o_done_oe || o_done_out;
  sequence s_gsr;
    o_global_set_reset ##1 !o_global_set_reset;
  endsequence
  // release with the wire already high and no wait or pipe options
  sequence s_rel;
    $rose(rel) ##0 (i_done_in && !i_lock_wait_en && !i_match_wait_en
      && !i_done_pipe);
  endsequence
  property p_gsr;
    i_last_frame && !i_write_end && o_sync_seen && !o_crc_error |=> s_gsr;
  endproperty
  a_gsr: assert property (p_gsr)
    else $error("set/reset pulse wrong after last frame");
  property p_fail;
    o_crc_error |-> o_init_oe && !o_init_out && o_done_oe && !o_done_out;
  endproperty
  a_fail: assert property (p_fail)
    else $error("failed state pins wrong");
  property p_step;
    $changed(o_phase) |-> o_phase == 3'($past(o_phase) + 3'h1)
      || o_phase == 3'h0;
  endproperty
  a_step: assert property (p_step)
    else $error("phase skipped");
  property p_eos;
    $rose(o_end_of_startup_flag) |-> o_phase == 3'h7
      && o_global_write_enable && !o_global_output_tristate;
  endproperty
  a_eos: assert property (p_eos)
    else $error("end flag outside last phase");
  property p_gts;
    $fell(o_global_output_tristate) |-> o_phase == i_gts_phase;
  endproperty
  a_gts: assert property (p_gts)
    else $error("tristate release in wrong phase");
  property p_gwe;
    $rose(o_global_write_enable) |-> o_phase == i_gwe_phase;
  endproperty
  a_gwe: assert property (p_gwe)
    else $error("write enable in wrong phase");
  property p_hold;
    (o_phase == i_done_phase && !i_done_in)[*4] |=> o_phase == i_done_phase;
  endproperty
  a_hold: assert property (p_hold)
    else $error("left done phase with done low");
  property p_fin;
    s_rel |-> ##[4:10] $rose(o_end_of_startup_flag);
  endproperty
  a_fin: assert property (p_fin)
    else $error("startup end out of range after release");
endmodule
`default_nettype wire

//--- tb/tb_cfg_startup_seq.sv
// self-checking bench for the check sum and startup sequencer
// assumes the peer model resolves the shared done and init wires
`default_nettype none
`include "cfg_startup_params.svh"
module tb_cfg_startup_seq;
  import cfg_startup_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CLR = 4;
  logic       clk = 0, rst = 1, prog_n = 0, hold_d = 0, hold_i = 0, vld = 0;
  logic       wend = 0, last = 0, drv = 0, pipe = 0, lk_en = 0, lk = 0;
  logic       mt_en = 0, mt = 0;
  logic [2:0] mode = 3'h0, gp = 3'h5, wp = 3'h6, dp = 3'h4;
  logic [2:0] lp = 3'h5, mp = 3'h6;
  word_t      wd = '0, exp_crc = '0, crc;
  logic       init_o, init_e, done_o, done_e, dw, iw, sync, err;
  logic       global_set_reset, global_output_tristate, global_write_enable, end_of_startup_flag;
  logic [2:0] omode, ph;
  int         mismatches = 0, check_count = 0, n;
  // 25 MHz config clock
  always #20 clk = ~clk;
  cfg_startup_seq #(.CLEAR_CYCLES(CLR)) u_dut (.i_clk(clk), .i_rst(rst),
    .i_program_reset_n(prog_n), .i_init_in(iw), .i_done_in(dw),
    .i_mode_pins(mode), .i_word_valid(vld), .i_word(wd),
    .i_write_end(wend), .i_last_frame(last), .i_expected_crc(exp_crc),
    .i_gts_phase(gp), .i_gwe_phase(wp), .i_done_phase(dp),
    .i_lock_wait_en(lk_en), .i_lock_phase(lp), .i_clocks_locked(lk),
    .i_match_wait_en(mt_en), .i_match_phase(mp),
    .i_impedance_matched(mt), .i_drive_done(drv), .i_done_pipe(pipe),
    .o_init_out(init_o), .o_init_oe(init_e), .o_done_out(done_o),
    .o_done_oe(done_e), .o_mode(omode), .o_sync_seen(sync),
    .o_crc_error(err), .o_global_set_reset(global_set_reset),
    .o_global_output_tristate(global_output_tristate), .o_global_write_enable(global_write_enable),
    .o_end_of_startup_flag(end_of_startup_flag), .o_phase(ph));
  cfg_peer_model u_peer (.i_done_out(done_o), .i_done_oe(done_e),
    .i_init_out(init_o), .i_init_oe(init_e), .i_hold_done(hold_d),
    .i_hold_init(hold_i), .o_done_wire(dw), .o_init_wire(iw));
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, want, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // reference check sum, msb first, kept apart from the design's own
  function automatic word_t crc_step(word_t c, word_t w);
    for (int i = 31; i >= 0; i--)
      c = {c[30:0], 1'b0} ^ ((c[31] ^ w[i]) ? `CFG_CRC_POLY : '0);
    return c;
  endfunction
  // valid stays up between back-to-back words; the caller drops it
  task automatic word(input word_t w);
    wd = w;
    vld = 1;
    cyc(1);
  endtask
  // program pulse, memory clear, then a delayed init rise
  task automatic boot(input logic [2:0] m);
    prog_n = 0;
    hold_i = 1;
    cyc(4);
    chk("gts prog", global_output_tristate, 1);
    chk("eos prog", end_of_startup_flag, 0);
    chk("err prog", err, 0);
    prog_n = 1;
    mode = m;
    cyc(CLR);
    chk("init clear", init_e, 1);
    cyc(CLR + 4);
    chk("init done", init_e, 0);
    hold_i = 0;
    cyc(4);
    chk("mode", omode, m);
  endtask
  // words before sync are junk; bad_wr and bad_pre corrupt the checks
  task automatic load(input int k, input logic bad_wr, input logic bad_pre);
    crc = `CFG_CRC_INIT;
    word(32'h1234_5678);
    chk("sync junk", sync, 0);
    word(`CFG_SYNC_WORD);
    chk("sync", sync, 1);
    for (int i = 0; i < k; i++) begin
      word(32'h0f0f_0000 + i);
      crc = crc_step(crc, 32'h0f0f_0000 + i);
    end
    vld = 0;
    exp_crc = crc ^ 32'(bad_wr);
    cyc(1);
    wend = 1;
    cyc(1);
    wend = 0;
    cyc(1);
    chk("write check", err, bad_wr);
    exp_crc = crc ^ 32'(bad_pre);
    last = 1;
    cyc(1);
    last = 0;
    chk("gsr", global_set_reset, !bad_wr);
    cyc(2);
    chk("pre check", err, bad_wr | bad_pre);
    chk("init err", iw, !(bad_wr | bad_pre));
  endtask
  task automatic wait_eos();
    n = 0;
    while (end_of_startup_flag !== 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    chk("eos", end_of_startup_flag, 1);
  endtask
  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    cyc(4);
    rst = 0;
    chk("gts rst", global_output_tristate, 1);
    chk("gwe rst", global_write_enable, 0);
    boot(3'h5);
    load(3, 0, 0);
    wait_eos();
    chk("gts run", global_output_tristate, 0);
    chk("gwe run", global_write_enable, 1);
    chk("done od", {done_e, dw}, 2'b01);
    drv = 1;
    pipe = 1;
    dp = 3'h1;
    gp = 3'h2;
    wp = 3'h3;
    lk_en = 1;
    mt_en = 1;
    hold_d = 1;
    boot(3'h2);
    load(2, 0, 0);
    cyc(20);
    chk("done hold", ph, 3'h1);
    chk("done drv", {done_e, done_o}, 2'b11);
    chk("gts order", global_output_tristate, 1);
    hold_d = 0;
    cyc(3);
    chk("done pipe", ph, 3'h1);
    cyc(5);
    chk("lock wait", ph, 3'h5);
    lk = 1;
    cyc(3);
    chk("match wait", ph, 3'h6);
    mt = 1;
    wait_eos();
    boot(3'h3);
    load(2, 1, 0);
    cyc(20);
    chk("fail eos", end_of_startup_flag, 0);
    chk("fail done", dw, 0);
    boot(3'h6);
    load(1, 0, 1);
    cyc(20);
    chk("pre gts", global_output_tristate, 1);
    conclude();
  end
  // watchdog well beyond the few hundred cycles the tests take
  initial begin
    cyc(3000);
    mismatches++;
    conclude();
  end
endmodule
bind cfg_startup_seq cfg_startup_seq_asserts u_chk (.i_clk(i_clk),
  .i_rst(i_rst), .i_done_in(i_done_in), .i_write_end(i_write_end),
  .i_last_frame(i_last_frame), .i_gts_phase(i_gts_phase),
  .i_gwe_phase(i_gwe_phase), .i_done_phase(i_done_phase),
  .i_lock_wait_en(i_lock_wait_en), .i_match_wait_en(i_match_wait_en),
  .i_done_pipe(i_done_pipe), .o_init_out(o_init_out),
  .o_init_oe(o_init_oe), .o_done_out(o_done_out), .o_done_oe(o_done_oe),
  .o_sync_seen(o_sync_seen), .o_crc_error(o_crc_error),
  .o_global_set_reset(o_global_set_reset),
  .o_global_output_tristate(o_global_output_tristate),
  .o_global_write_enable(o_global_write_enable),
  .o_end_of_startup_flag(o_end_of_startup_flag), .o_phase(o_phase));
`default_nettype wire
